//--- shared/pcd_pkg.sv
// Constants for the PLL clock select and divider block
package pcd_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_CLOCK_CONTROL = 5'h00;
    localparam logic [4:0] OFS_IRQ_STATUS    = 5'h04;
    localparam logic [4:0] OFS_IRQ_CLEAR     = 5'h08;
    localparam logic [4:0] OFS_IRQ_ENABLE    = 5'h0c;

    // ------------------------------------------------------------
    // clock_control field positions
    // ------------------------------------------------------------
    localparam int unsigned POS_LOCK   = 7;
    localparam int unsigned POS_POWER  = 6;
    localparam int unsigned POS_SELECT = 5;
    localparam int unsigned POS_BCS_LO = 2;
    localparam int unsigned POS_MCS_LO = 0;
    localparam int unsigned BCS_W      = 3;
    localparam int unsigned MCS_W      = 2;

    // ------------------------------------------------------------
    // Interrupt status bit positions
    // ------------------------------------------------------------
    localparam int unsigned IRQ_LOCK_GAINED = 0;
    localparam int unsigned IRQ_LOCK_LOST   = 1;
    localparam int unsigned IRQ_W           = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]        RST_CLOCK_CONTROL = 8'h00;
    localparam logic [IRQ_W-1:0]  RST_IRQ_ENABLE    = 2'h0;

    // ------------------------------------------------------------
    // Lock measurement, counted in edges
    // ------------------------------------------------------------
    localparam logic [7:0] LOCK_WINDOW_EDGES = 8'h40;
    localparam logic [7:0] LOCK_TARGET_EDGES = 8'h40;
    localparam logic [7:0] LOCK_MIN_EDGES    = 8'h20;
    localparam logic [7:0] LOCK_MAX_EDGES    = 8'h80;

    // ------------------------------------------------------------
    // Bus responses
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- verilog/pcd_pow2_div.sv
// Power-of-two tick divider
`timescale 1ns/100ps

module pcd_pow2_div #(
    parameter int unsigned SEL_W = 3
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             tick_in,
    input  wire logic [SEL_W-1:0] sel,
    output logic                  tick_out
);

    localparam int unsigned CNT_W = (1 << SEL_W) - 1;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             out;
    } pcd_div_st_t;

    pcd_div_st_t q;
    pcd_div_st_t d;

    // ------------------------------------------------------------
    // Mask of counter bits used for a divide by two to the sel
    // ------------------------------------------------------------
    function automatic logic [CNT_W-1:0] pcd_mask(
        input logic [SEL_W-1:0] s
    );
        pcd_mask = CNT_W'((1 << s) - 1);
    endfunction

    always_comb begin
        d     = q;
        d.out = 1'b0;
        if (tick_in) begin
            if ((q.cnt & pcd_mask(sel)) == pcd_mask(sel)) begin
                d.out = 1'b1;
                d.cnt = '0;
            end else begin
                d.cnt = q.cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick_out = q.out;

endmodule

//--- verilog/pcd_clock_control.sv
// PLL clock select, lock flag and clock dividers with AXI4-Lite registers
`timescale 1ns/100ps

module pcd_clock_control (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [4:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [4:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    input  wire logic        xtal_clk_in,
    input  wire logic        pll_clk_in,
    output logic             pll_power_on,
    output logic             pll_lock_flag,
    output logic             selected_source_clock,
    output logic             system_clock_tick,
    output logic             bus_clock_tick,
    output logic             module_clock_tick,
    output logic             irq
);

    typedef struct packed {
        logic                       xtal_s1;
        logic                       xtal_s2;
        logic                       pll_s1;
        logic                       pll_s2;
        logic                       xtal_prev;
        logic                       pll_prev;
        logic                       src_prev;
        logic                       use_pll;
        logic                       src_clk;
        logic                       power;
        logic                       src_sel;
        logic [pcd_pkg::BCS_W-1:0]  bcs;
        logic [pcd_pkg::MCS_W-1:0]  mcs;
        logic                       lock;
        logic [7:0]                 win_cnt;
        logic [7:0]                 pll_cnt;
        logic [pcd_pkg::IRQ_W-1:0]  irq_stat;
        logic [pcd_pkg::IRQ_W-1:0]  irq_en;
        logic                       irq;
        logic                       aw_got;
        logic                       w_got;
        logic [4:0]                 waddr;
        logic [7:0]                 wdata;
        logic                       wstrb0;
        logic                       awready;
        logic                       wready;
        logic                       bvalid;
        logic [1:0]                 bresp;
        logic                       arready;
        logic                       rvalid;
        logic [7:0]                 rdata;
        logic [1:0]                 rresp;
    } pcd_state_t;

    pcd_state_t q;
    pcd_state_t d;

    logic       src_tick;
    logic       sys_tick;
    logic       bus_tick;
    logic       mod_tick;
    logic [7:0] ctl_view;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic pcd_mapped(input logic [4:0] a);
        pcd_mapped = (a == pcd_pkg::OFS_CLOCK_CONTROL) ||
                     (a == pcd_pkg::OFS_IRQ_STATUS)    ||
                     (a == pcd_pkg::OFS_IRQ_CLEAR)     ||
                     (a == pcd_pkg::OFS_IRQ_ENABLE);
    endfunction

    // ------------------------------------------------------------
    // Clock control register image
    // ------------------------------------------------------------
    always_comb begin
        ctl_view                      = 8'h00;
        ctl_view[pcd_pkg::POS_LOCK]   = q.lock;
        ctl_view[pcd_pkg::POS_POWER]  = q.power;
        ctl_view[pcd_pkg::POS_SELECT] = q.src_sel;
        ctl_view[pcd_pkg::POS_BCS_LO +: pcd_pkg::BCS_W] = q.bcs;
        ctl_view[pcd_pkg::POS_MCS_LO +: pcd_pkg::MCS_W] = q.mcs;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic                      xtal_edge;
        logic                      pll_edge;
        logic                      src_level;
        logic                      win_end;
        logic [7:0]                pll_next;
        logic                      lock_next;
        logic                      do_write;
        logic [pcd_pkg::IRQ_W-1:0] ev;
        logic [pcd_pkg::IRQ_W-1:0] clr;
        xtal_edge = 1'b0;
        pll_edge  = 1'b0;
        src_level = 1'b0;
        win_end   = 1'b0;
        pll_next  = 8'h00;
        lock_next = 1'b0;
        do_write  = 1'b0;
        ev        = '0;
        clr       = '0;
        d         = q;

        // Pin sampling, two flops before any use
        d.xtal_s1   = xtal_clk_in;
        d.xtal_s2   = q.xtal_s1;
        d.pll_s1    = pll_clk_in;
        d.pll_s2    = q.pll_s1;
        d.xtal_prev = q.xtal_s2;
        d.pll_prev  = q.pll_s2;
        xtal_edge   = q.xtal_s2 && !q.xtal_prev;
        pll_edge    = q.pll_s2 && !q.pll_prev && q.power;

        // Frequency window on crystal edges
        pll_next = q.pll_cnt;
        if (pll_edge && q.pll_cnt != 8'hff) begin
            pll_next = q.pll_cnt + 8'h01;
        end
        lock_next = q.lock;
        d.pll_cnt = pll_next;
        if (xtal_edge) begin
            win_end = (q.win_cnt == pcd_pkg::LOCK_WINDOW_EDGES - 8'h01);
            d.win_cnt = win_end ? 8'h00 : q.win_cnt + 8'h01;
            if (win_end) begin
                lock_next = (pll_next >= pcd_pkg::LOCK_MIN_EDGES) &&
                            (pll_next <= pcd_pkg::LOCK_MAX_EDGES);
                d.pll_cnt = 8'h00;
            end
        end
        if (!q.power) begin
            lock_next = 1'b0;
            d.win_cnt = 8'h00;
            d.pll_cnt = 8'h00;
        end
        d.lock = lock_next;
        ev[pcd_pkg::IRQ_LOCK_GAINED] = lock_next && !q.lock;
        ev[pcd_pkg::IRQ_LOCK_LOST]   = !lock_next && q.lock;

        // Source mux, PLL only while locked
        d.use_pll = q.src_sel && q.lock && q.power;
        src_level = q.use_pll ? q.pll_s2 : q.xtal_s2;
        d.src_clk  = src_level;
        d.src_prev = q.src_clk;

        // Write address and data, taken in either order
        if (s_axi_awvalid && q.awready) begin
            d.aw_got  = 1'b1;
            d.waddr   = s_axi_awaddr;
            d.awready = 1'b0;
        end
        if (s_axi_wvalid && q.wready) begin
            d.w_got  = 1'b1;
            d.wdata  = s_axi_wdata[7:0];
            d.wstrb0 = s_axi_wstrb[0];
            d.wready = 1'b0;
        end
        if (q.aw_got && q.w_got && !q.bvalid) begin
            do_write = q.wstrb0;
            d.aw_got = 1'b0;
            d.w_got  = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = pcd_mapped(q.waddr) ? pcd_pkg::RESP_OKAY
                                           : pcd_pkg::RESP_SLVERR;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid  = 1'b0;
            d.awready = 1'b1;
            d.wready  = 1'b1;
        end

        // Register effects of a write
        if (do_write) begin
            unique case (q.waddr)
                pcd_pkg::OFS_CLOCK_CONTROL: begin
                    d.power   = q.wdata[pcd_pkg::POS_POWER];
                    d.src_sel = q.wdata[pcd_pkg::POS_SELECT];
                    d.bcs = q.wdata[pcd_pkg::POS_BCS_LO +:
                                    pcd_pkg::BCS_W];
                    d.mcs = q.wdata[pcd_pkg::POS_MCS_LO +:
                                    pcd_pkg::MCS_W];
                end
                pcd_pkg::OFS_IRQ_CLEAR: begin
                    clr = q.wdata[pcd_pkg::IRQ_W-1:0];
                end
                pcd_pkg::OFS_IRQ_ENABLE: begin
                    d.irq_en = q.wdata[pcd_pkg::IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // Sticky events, a new event beats a clear
        d.irq_stat = (q.irq_stat & ~clr) | ev;
        d.irq      = |(d.irq_stat & d.irq_en);

        // Read channel
        if (s_axi_arvalid && q.arready) begin
            d.arready = 1'b0;
            d.rvalid  = 1'b1;
            d.rresp   = pcd_mapped(s_axi_araddr) ? pcd_pkg::RESP_OKAY
                                                 : pcd_pkg::RESP_SLVERR;
            unique case (s_axi_araddr)
                pcd_pkg::OFS_CLOCK_CONTROL: d.rdata = ctl_view;
                pcd_pkg::OFS_IRQ_STATUS:
                    d.rdata = {6'h00, q.irq_stat};
                pcd_pkg::OFS_IRQ_ENABLE:
                    d.rdata = {6'h00, q.irq_en};
                default: d.rdata = 8'h00;
            endcase
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid  = 1'b0;
            d.arready = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q         <= '0;
            q.power   <= pcd_pkg::RST_CLOCK_CONTROL[pcd_pkg::POS_POWER];
            q.src_sel <= pcd_pkg::RST_CLOCK_CONTROL[pcd_pkg::POS_SELECT];
            q.bcs     <= pcd_pkg::RST_CLOCK_CONTROL[pcd_pkg::POS_BCS_LO +:
                                                    pcd_pkg::BCS_W];
            q.mcs     <= pcd_pkg::RST_CLOCK_CONTROL[pcd_pkg::POS_MCS_LO +:
                                                    pcd_pkg::MCS_W];
            q.irq_en  <= pcd_pkg::RST_IRQ_ENABLE;
            q.awready <= 1'b1;
            q.wready  <= 1'b1;
            q.arready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Divider chain
    // ------------------------------------------------------------
    // Rising edge of the muxed source; suppressed on a source switch
    assign src_tick = q.src_clk && !q.src_prev && (q.use_pll == d.use_pll);

    pcd_pow2_div #(
        .SEL_W    (pcd_pkg::BCS_W)
    ) u_base_div (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .tick_in  (src_tick),
        .sel      (q.bcs),
        .tick_out (sys_tick)
    );

    pcd_pow2_div #(
        .SEL_W    (1)
    ) u_bus_div (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .tick_in  (sys_tick),
        .sel      (1'b1),
        .tick_out (bus_tick)
    );

    pcd_pow2_div #(
        .SEL_W    (pcd_pkg::MCS_W)
    ) u_mod_div (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .tick_in  (bus_tick),
        .sel      (q.mcs),
        .tick_out (mod_tick)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign s_axi_awready         = q.awready;
    assign s_axi_wready          = q.wready;
    assign s_axi_bvalid          = q.bvalid;
    assign s_axi_bresp           = q.bresp;
    assign s_axi_arready         = q.arready;
    assign s_axi_rvalid          = q.rvalid;
    assign s_axi_rdata           = {24'h000000, q.rdata};
    assign s_axi_rresp           = q.rresp;
    assign pll_power_on          = q.power;
    assign pll_lock_flag         = q.lock;
    assign selected_source_clock = q.src_clk;
    assign system_clock_tick     = sys_tick;
    assign bus_clock_tick        = bus_tick;
    assign module_clock_tick     = mod_tick;
    assign irq                   = q.irq;

endmodule

//--- dv/pcd_clock_control_chk.sv
// Bus and clock assertions for the clock control block
`timescale 1ns/100ps

module pcd_clock_control_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        xtal_clk_in,
    input wire logic        pll_clk_in,
    input wire logic        pll_power_on,
    input wire logic        pll_lock_flag,
    input wire logic        selected_source_clock
);
    logic [11:0] still_q;
    logic        pll_prev_q;

    // ----------
    // Cycles since the PLL pin last moved
    // ----------
    always_ff @(posedge aclk) begin
        pll_prev_q <= pll_clk_in;
        if (!aresetn || pll_clk_in != pll_prev_q)
            still_q <= 12'h000;
        else if (still_q != 12'hfff)
            still_q <= still_q + 12'h001;
    end

    // ----------
    // Assertions
    // ----------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped early");

    property p_b_lat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##[1:3] s_axi_bvalid;
    endproperty
    a_b_lat: assert property (p_b_lat)
        else $error("write response late");

    property p_r_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r_lat: assert property (p_r_lat)
        else $error("read data late");

    property p_r_hi;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
    endproperty
    a_r_hi: assert property (p_r_hi)
        else $error("read data upper bits set");

    property p_lock_off;
        !pll_power_on [*3] |-> !pll_lock_flag;
    endproperty
    a_lock_off: assert property (p_lock_off)
        else $error("lock while PLL off");

    property p_lock_rise;
        $rose(pll_lock_flag) |-> pll_power_on;
    endproperty
    a_lock_rise: assert property (p_lock_rise)
        else $error("lock rose with PLL off");

    property p_src_xtal;
        (!pll_lock_flag && $stable(xtal_clk_in)) [*6]
            |-> selected_source_clock == xtal_clk_in;
    endproperty
    a_src_xtal: assert property (p_src_xtal)
        else $error("source not crystal while unlocked");

    property p_lock_still;
        still_q > 12'h898 |-> !pll_lock_flag;
    endproperty
    a_lock_still: assert property (p_lock_still)
        else $error("lock held with PLL stopped");
endmodule

bind pcd_clock_control pcd_clock_control_chk u_chk (.*);

//--- dv/tb_pcd_clock_control.sv
// Self-checking bench for the clock control block
`timescale 1ns/100ps

module tb_pcd_clock_control;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_arready, s_axi_rvalid, s_axi_rready, xtal_clk_in;
    logic        pll_clk_in, pll_power_on, pll_lock_flag, irq;
    logic        selected_source_clock, system_clock_tick;
    logic        bus_clock_tick, module_clock_tick;
    logic [4:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [2:0]  xc;
    int          n_fail, comparisons, pll_half, pc;
    int          ctrl_m, lock_m, st_m, en_m;

    pcd_clock_control uut (.*);

    // ----------
    // Clocks: crystal period 16, PLL period twice pll_half
    // ----------
    always #10 aclk = ~aclk;
    always @(posedge aclk) begin
        xc <= xc + 3'h1;
        if (xc == 3'h7)
            xtal_clk_in <= ~xtal_clk_in;
        if (pll_half == 0 || pc >= pll_half - 1)
            pc <= 0;
        else
            pc <= pc + 1;
        if (pll_half != 0 && pc >= pll_half - 1)
            pll_clk_in <= ~pll_clk_in;
    end

    // ----------
    // Checking and bus tasks
    // ----------
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    function automatic logic [1:0] resp(input logic [4:0] a);
        return (a > 5'h0c) ? pcd_pkg::RESP_SLVERR : pcd_pkg::RESP_OKAY;
    endfunction

    task automatic wr(input logic [4:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        int k = 0;
        bit aw = 0, w = 0;
        if (s[0] && a == pcd_pkg::OFS_CLOCK_CONTROL)
            ctrl_m = d[6:0];
        if (s[0] && a == pcd_pkg::OFS_IRQ_CLEAR)
            st_m = st_m & ~int'(d[1:0]);
        if (s[0] && a == pcd_pkg::OFS_IRQ_ENABLE)
            en_m = d[1:0];
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw && w) && k < 99) begin
            @(posedge aclk);
            k++;
            aw |= s_axi_awready;
            w |= s_axi_wready;
            s_axi_awvalid <= !aw;
            s_axi_wvalid <= !w;
        end
        while (!s_axi_bvalid && k < 199) begin
            @(posedge aclk);
            k++;
        end
        repeat ($urandom_range(2)) @(posedge aclk);
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        check("bvalid", 32'(s_axi_bvalid), 32'h1);
        check("bresp", 32'(s_axi_bresp), 32'(resp(a)));
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [4:0] a);
        int k = 0;
        logic [31:0] e;
        case (a)
            pcd_pkg::OFS_CLOCK_CONTROL: e = {lock_m[0], ctrl_m[6:0]};
            pcd_pkg::OFS_IRQ_STATUS: e = st_m;
            pcd_pkg::OFS_IRQ_ENABLE: e = en_m;
            default: e = 0;
        endcase
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
        end while (!s_axi_arready && k < 99);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid && k < 199) begin
            @(posedge aclk);
            k++;
        end
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        check("rdata", s_axi_rdata, e);
        check("rresp", 32'(s_axi_rresp), 32'(resp(a)));
        check("power", 32'(pll_power_on), 32'(ctrl_m[6]));
        check("lock", 32'(pll_lock_flag), 32'(lock_m[0]));
        check("irq", 32'(irq), 32'((st_m & en_m) != 0));
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    // Cycles between the last two of three ticks
    task automatic period(input int w, input int exp);
        int k;
        for (int n = 0; n < 3; n++) begin
            k = 0;
            do begin
                @(posedge aclk);
                k++;
            end while (!(w == 0 ? system_clock_tick : w == 1 ?
                         bus_clock_tick : module_clock_tick) && k < 9999);
        end
        check("period", k, exp);
    endtask

    // ----------
    // Main sequence
    // ----------
    initial begin
        int tbl[5];
        int nl;
        // Rates only cross the lock range once per step
        tbl = '{0, 20, 8, 5, 3};
        aclk = 0;
        aresetn = 0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, xtal_clk_in, pll_clk_in, xc} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {pc, ctrl_m, lock_m, st_m, en_m} = '0;
        pll_half = 3;
        void'($urandom(46));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int a = 0; a < 24; a += 4)
            rd(5'(a));
        wr(5'h00, 32'hbf, 4'h1);
        rd(5'h00);
        wr(5'h00, 32'h00, 4'he);
        wr(5'h04, 32'hff, 4'hf);
        wr(5'h14, 32'h01, 4'hf);
        rd(5'h00);
        for (int i = 0; i < 6; i++) begin
            wr(5'h00, $urandom & 32'hffff_ffbf, 4'hf);
            rd(5'h00);
        end
        for (int j = 0; j < 8; j++) begin
            wr(5'h00, 32'((j << 2) | (j & 3)), 4'h1);
            period(0, 16 << j);
            period(1, 32 << j);
            if (j < 4)
                period(2, 32 << (2 * j));
        end
        wr(5'h00, 32'h02, 4'h1);
        period(2, 128);
        wr(5'h00, 32'h08, 4'h1);
        period(2, 128);
        wr(5'h00, 32'h60, 4'h1);
        for (int t = 0; t < 5; t++) begin
            pll_half <= tbl[t];
            repeat (2500) @(posedge aclk);
            nl = tbl[t] >= 4 && tbl[t] <= 16;
            st_m |= (nl && !lock_m) ? 1 : (!nl && lock_m) ? 2 : 0;
            lock_m = nl;
            rd(5'h00);
            rd(5'h04);
            period(0, nl ? 2 * tbl[t] : 16);
            if (t == 3) begin
                // Locked but crystal chosen
                wr(5'h00, 32'h40, 4'h1);
                period(0, 16);
                wr(5'h00, 32'h60, 4'h1);
            end
        end
        wr(5'h0c, 32'h1, 4'h1);
        rd(5'h04);
        wr(5'h08, 32'h1, 4'h1);
        rd(5'h04);
        wr(5'h0c, 32'h3, 4'h1);
        rd(5'h0c);
        wr(5'h08, 32'h2, 4'h1);
        rd(5'h04);
        wr(5'h00, 32'h0, 4'h1);
        rd(5'h00);
        print_verdict;
    end

    initial begin
        repeat (90000) @(posedge aclk);
        n_fail++;
        print_verdict;
    end
endmodule
